// >>> shared/tob_pkg.sv
package tob_pkg;
  // ---------------------------------------------------------------------------
  // Register addresses.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_TARGET_SELECT = 8'h01;
  localparam logic [7:0] ADDR_TRIM_SOURCE_SELECT = 8'h16;
  localparam logic [7:0] ADDR_INPUT_COMMON_MODE_TRIM = 8'h1B;
  localparam logic [7:0] ADDR_INPUT_IMPEDANCE_TRIM = 8'h1C;
  localparam logic [7:0] ADDR_CORE_POWER_DOWN = 8'h5C;
  localparam logic [7:0] ADDR_OUTPUT_SWING_SELECT = 8'h6A;
  localparam logic [7:0] ADDR_INPUT_COMMON_MODE_READBACK = 8'h6F;
  localparam logic [7:0] ADDR_INPUT_IMPEDANCE_READBACK = 8'h70;
  // ---------------------------------------------------------------------------
  // Reset values and fields.
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_TRIM_SOURCE_SELECT = 16'h0000;
  localparam logic [15:0] RST_INPUT_COMMON_MODE_TRIM = 16'h0010;
  localparam logic [15:0] RST_INPUT_IMPEDANCE_TRIM = 16'h8000;
  localparam logic [15:0] RST_OUTPUT_SWING_SELECT = 16'h0000;
  localparam logic [15:0] RST_TARGET_SELECT = 16'h0000;
  localparam logic [3:0] RST_CORE_POWER_DOWN = 4'h0;
  localparam logic [15:0] RST_READ_DATA = 16'h0000;
  localparam int OFFSET_SOURCE_BIT = 0;
  localparam int COMMON_MODE_SOURCE_BIT = 1;
  localparam int IMPEDANCE_SOURCE_BIT = 2;
  localparam logic [15:0] TRIM_SOURCE_WRITE_MASK = 16'h0007;
  localparam int IMPEDANCE_WIDTH = 4;
  localparam int COMMON_MODE_WIDTH = 5;
  // ---------------------------------------------------------------------------
  // Target-select, source-select and power-down codes; core count.
  // ---------------------------------------------------------------------------
  localparam logic [15:0] TARGET_CORE_D = 16'h0003;
  localparam logic [15:0] TARGET_ALL_CORES = 16'h0004;
  localparam logic [15:0] TARGET_GLOBAL = 16'h0007;
  localparam logic [15:0] SOURCE_IMPEDANCE_ONLY = 16'h0004;
  localparam logic [15:0] SOURCE_COMMON_MODE_ONLY = 16'h0002;
  localparam logic [15:0] POWER_DOWN_VALUE = 16'h0001;
  localparam int NUM_CORES = 4;
  // ---------------------------------------------------------------------------
  // Host sequencer states.
  // ---------------------------------------------------------------------------
  typedef enum logic [5:0] {
    TOB_IDLE = 6'b000001,
    TOB_SEL = 6'b000010,
    TOB_RD = 6'b000100,
    TOB_RDW = 6'b001000,
    TOB_SRC = 6'b010000,
    TOB_TRIM = 6'b100000
  } tob_host_state_e;
endpackage : tob_pkg

// >>> shared/tob_if.sv
`timescale 1ns/1ps
interface tob_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  modport device (input wr, input rd, input addr, input wdata, output rdata, output rvalid);
  modport host (output wr, output rd, output addr, output wdata, input rdata, input rvalid);
endinterface : tob_if

// >>> src/tob_device.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Swing select resets 0 reduced; 1 standard.
// [R2] Swing setting drives all output groups.
// [R3] Source bit 0 picks offset trims.
// [R4] Source bit 1 picks common-mode trim.
// [R5] Source bit 2 picks impedance trim.
// [R6] Source select at 16, resets zero.
// [R7] Impedance trim 4 bits, 1C/70, 8000.
// [R8] Common-mode trim 5 bits, 1B/6F, 0010.
// [R9] Host overrides via target 0007 first.
// [R10] Host sets impedance bit by read-modify-write.
// [R11] Host sets common-mode bit by read-modify-write.
// [R12] Target 0003 addresses core D only.
// [R13] Power-down write affects targeted core only.
// [R14] Target 0004 broadcasts to all cores.
// [R15] Read-back returns the trim in effect.
module tob_device (
  input wire logic i_clock,
  input wire logic i_resetn,
  tob_if.device bus,
  input wire logic [3:0] i_fuse_impedance,
  input wire logic [4:0] i_fuse_common_mode,
  output logic [3:0] o_impedance_trim,
  output logic [4:0] o_common_mode_trim,
  output logic o_offset_from_serial,
  output logic o_swing_standard,
  output logic o_swing_data,
  output logic o_swing_ready,
  output logic o_swing_parity,
  output logic o_swing_in_range,
  output logic [3:0] o_core_power_down
);
  // ---------------------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------------------
  logic [15:0] target_reg;
  logic [15:0] source_reg;
  logic [15:0] cm_reg;
  logic [15:0] imp_reg;
  logic [15:0] swing_reg;
  logic [3:0] pd_reg;
  logic [15:0] rdata_reg;
  logic rvalid_reg;
  logic [3:0] fuse_imp_meta_reg;
  logic [4:0] fuse_cm_meta_reg;
  logic [3:0] fuse_imp_reg;
  logic [4:0] fuse_cm_reg;
  logic [3:0] pd_next;
  logic [15:0] rdata_next;
  // ---------------------------------------------------------------------------
  // Address decoding.
  // ---------------------------------------------------------------------------
  // Tells whether a write strobe hits the given register address.
  function automatic logic write_hit(input logic wr, input logic [7:0] addr, input logic [7:0] reg_addr);
    write_hit = wr && (addr == reg_addr);
  endfunction : write_hit
  wire wr_target = write_hit(bus.wr, bus.addr, tob_pkg::ADDR_TARGET_SELECT);
  wire wr_source = write_hit(bus.wr, bus.addr, tob_pkg::ADDR_TRIM_SOURCE_SELECT);
  wire wr_cm = write_hit(bus.wr, bus.addr, tob_pkg::ADDR_INPUT_COMMON_MODE_TRIM);
  wire wr_imp = write_hit(bus.wr, bus.addr, tob_pkg::ADDR_INPUT_IMPEDANCE_TRIM);
  wire wr_swing = write_hit(bus.wr, bus.addr, tob_pkg::ADDR_OUTPUT_SWING_SELECT);
  wire wr_pd = write_hit(bus.wr, bus.addr, tob_pkg::ADDR_CORE_POWER_DOWN);
  wire target_all = target_reg == tob_pkg::TARGET_ALL_CORES;
  wire target_single = target_reg < 16'(tob_pkg::NUM_CORES);
  wire [1:0] target_core = target_reg[1:0];
  wire [15:0] source_wr_value = bus.wdata & tob_pkg::TRIM_SOURCE_WRITE_MASK; // see [R6]
  wire [15:0] swing_wr_value = {15'h0000, bus.wdata[0]}; // see [R1]
  // ---------------------------------------------------------------------------
  // Effective trims.
  // ---------------------------------------------------------------------------
  wire [3:0] imp_eff = source_reg[tob_pkg::IMPEDANCE_SOURCE_BIT] ? imp_reg[3:0] : fuse_imp_reg; // see [R5] [R15]
  wire [4:0] cm_eff = source_reg[tob_pkg::COMMON_MODE_SOURCE_BIT] ? cm_reg[4:0] : fuse_cm_reg; // see [R4] [R15]
  assign o_impedance_trim = imp_eff;
  assign o_common_mode_trim = cm_eff;
  assign o_offset_from_serial = source_reg[tob_pkg::OFFSET_SOURCE_BIT]; // see [R3]
  assign o_swing_standard = swing_reg[0]; // see [R1]
  assign o_swing_data = swing_reg[0]; // see [R2]
  assign o_swing_ready = swing_reg[0]; // see [R2]
  assign o_swing_parity = swing_reg[0]; // see [R2]
  assign o_swing_in_range = swing_reg[0]; // see [R2]
  assign o_core_power_down = pd_reg;
  assign bus.rdata = rdata_reg;
  assign bus.rvalid = rvalid_reg;
  // ---------------------------------------------------------------------------
  // Power-down per targeted core.
  // ---------------------------------------------------------------------------
  always_comb
  begin
    pd_next = pd_reg;
    if (wr_pd)
    begin
      if (target_all) // see [R14]
      begin
        pd_next = {4{bus.wdata[0]}};
      end
      else if (target_single) // see [R12] [R13]
      begin
        pd_next[target_core] = bus.wdata[0];
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Read mux.
  // ---------------------------------------------------------------------------
  always_comb
  begin
    unique case (bus.addr)
      tob_pkg::ADDR_TARGET_SELECT: rdata_next = target_reg;
      tob_pkg::ADDR_TRIM_SOURCE_SELECT: rdata_next = source_reg; // see [R6]
      tob_pkg::ADDR_INPUT_COMMON_MODE_TRIM: rdata_next = cm_reg;
      tob_pkg::ADDR_INPUT_IMPEDANCE_TRIM: rdata_next = imp_reg;
      tob_pkg::ADDR_OUTPUT_SWING_SELECT: rdata_next = swing_reg;
      tob_pkg::ADDR_CORE_POWER_DOWN: rdata_next = {15'h0000, pd_reg[target_core]}; // see [R13]
      tob_pkg::ADDR_INPUT_COMMON_MODE_READBACK: rdata_next = {11'h000, cm_eff}; // see [R8] [R15]
      tob_pkg::ADDR_INPUT_IMPEDANCE_READBACK: rdata_next = {12'h000, imp_eff}; // see [R7] [R15]
      default: rdata_next = 16'h0000;
    endcase
  end
  // ---------------------------------------------------------------------------
  // Fuse synchroniser.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      fuse_imp_meta_reg <= 4'h0;
      fuse_cm_meta_reg <= 5'h00;
      fuse_imp_reg <= 4'h0;
      fuse_cm_reg <= 5'h00;
    end
    else
    begin
      fuse_imp_meta_reg <= i_fuse_impedance;
      fuse_cm_meta_reg <= i_fuse_common_mode;
      fuse_imp_reg <= fuse_imp_meta_reg;
      fuse_cm_reg <= fuse_cm_meta_reg;
    end
  end
  // ---------------------------------------------------------------------------
  // Target select.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      target_reg <= tob_pkg::RST_TARGET_SELECT;
    end
    else if (wr_target)
    begin
      target_reg <= bus.wdata; // see [R12] [R14]
    end
  end
  // ---------------------------------------------------------------------------
  // Trim source select and trim values.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      source_reg <= tob_pkg::RST_TRIM_SOURCE_SELECT; // see [R6]
      cm_reg <= tob_pkg::RST_INPUT_COMMON_MODE_TRIM; // see [R8]
      imp_reg <= tob_pkg::RST_INPUT_IMPEDANCE_TRIM; // see [R7]
    end
    else
    begin
      if (wr_source)
      begin
        source_reg <= source_wr_value; // see [R6]
      end
      if (wr_cm)
      begin
        cm_reg <= bus.wdata; // see [R8]
      end
      if (wr_imp)
      begin
        imp_reg <= bus.wdata; // see [R7]
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Output swing select.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      swing_reg <= tob_pkg::RST_OUTPUT_SWING_SELECT; // see [R1]
    end
    else if (wr_swing)
    begin
      swing_reg <= swing_wr_value; // see [R1]
    end
  end
  // ---------------------------------------------------------------------------
  // Core power-down state.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pd_reg <= tob_pkg::RST_CORE_POWER_DOWN;
    end
    else
    begin
      pd_reg <= pd_next; // see [R13]
    end
  end
  // ---------------------------------------------------------------------------
  // Read response.
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rdata_reg <= tob_pkg::RST_READ_DATA;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= bus.rd;
      if (bus.rd)
      begin
        rdata_reg <= rdata_next;
      end
    end
  end
endmodule : tob_device

// >>> src/tob_host.sv
`timescale 1ns/1ps
module tob_host (
  input wire logic i_clock,
  input wire logic i_resetn,
  tob_if.host bus,
  input wire logic i_start,
  input wire logic i_common_mode,
  input wire logic i_keep,
  input wire logic [15:0] i_value,
  output logic o_busy,
  output logic o_done
);
  // ---------------------------------------------------------------------------
  // Override sequencer.
  // ---------------------------------------------------------------------------
  tob_pkg::tob_host_state_e state_reg;
  tob_pkg::tob_host_state_e state_next;
  logic [15:0] src_reg;
  logic cm_reg;
  logic keep_reg;
  logic [15:0] val_reg;
  logic done_reg;
  wire [15:0] sel_bit = cm_reg ? tob_pkg::SOURCE_COMMON_MODE_ONLY : tob_pkg::SOURCE_IMPEDANCE_ONLY;
  wire [15:0] src_value = keep_reg ? (src_reg | sel_bit) : sel_bit; // see [R10] [R11]
  wire [7:0] trim_addr = cm_reg ? tob_pkg::ADDR_INPUT_COMMON_MODE_TRIM : tob_pkg::ADDR_INPUT_IMPEDANCE_TRIM;
  assign o_busy = state_reg != tob_pkg::TOB_IDLE;
  assign o_done = done_reg;
  always_comb
  begin
    state_next = state_reg;
    bus.wr = 1'b0;
    bus.rd = 1'b0;
    bus.addr = 8'h00;
    bus.wdata = 16'h0000;
    unique case (state_reg)
      tob_pkg::TOB_IDLE: if (i_start) state_next = tob_pkg::TOB_SEL;
      tob_pkg::TOB_SEL:
      begin
        bus.wr = 1'b1;
        bus.addr = tob_pkg::ADDR_TARGET_SELECT;
        bus.wdata = tob_pkg::TARGET_GLOBAL; // see [R9]
        state_next = keep_reg ? tob_pkg::TOB_RD : tob_pkg::TOB_SRC;
      end
      tob_pkg::TOB_RD:
      begin
        bus.rd = 1'b1;
        bus.addr = tob_pkg::ADDR_TRIM_SOURCE_SELECT;
        state_next = tob_pkg::TOB_RDW;
      end
      tob_pkg::TOB_RDW: if (bus.rvalid) state_next = tob_pkg::TOB_SRC;
      tob_pkg::TOB_SRC:
      begin
        bus.wr = 1'b1;
        bus.addr = tob_pkg::ADDR_TRIM_SOURCE_SELECT;
        bus.wdata = src_value; // see [R9]
        state_next = tob_pkg::TOB_TRIM;
      end
      tob_pkg::TOB_TRIM:
      begin
        bus.wr = 1'b1;
        bus.addr = trim_addr;
        bus.wdata = val_reg; // see [R9]
        state_next = tob_pkg::TOB_IDLE;
      end
      default: state_next = tob_pkg::TOB_IDLE;
    endcase
  end
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= tob_pkg::TOB_IDLE;
      src_reg <= 16'h0000;
      cm_reg <= 1'b0;
      keep_reg <= 1'b0;
      val_reg <= 16'h0000;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      done_reg <= state_reg == tob_pkg::TOB_TRIM;
      if (state_reg == tob_pkg::TOB_IDLE && i_start)
      begin
        cm_reg <= i_common_mode;
        keep_reg <= i_keep;
        val_reg <= i_value;
      end
      if (state_reg == tob_pkg::TOB_RDW && bus.rvalid)
        src_reg <= bus.rdata;
    end
  end
endmodule : tob_host

// >>> testbench/tob_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bus protocol checks between host and device.
// ----------------------------------------
module tob_props (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  wire sel_w = wr && addr == tob_pkg::ADDR_TARGET_SELECT && wdata == tob_pkg::TARGET_GLOBAL;
  wire imp_bit = wdata[tob_pkg::IMPEDANCE_SOURCE_BIT];
  wire cm_bit = wdata[tob_pkg::COMMON_MODE_SOURCE_BIT];
  sequence s_src_wr;
    wr && addr == tob_pkg::ADDR_TRIM_SOURCE_SELECT;
  endsequence
  sequence s_src_rd;
    rd && addr == tob_pkg::ADDR_TRIM_SOURCE_SELECT;
  endsequence
  a_rvalid_after_rd: assert property (rd |=> rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  a_no_wr_rd: assert property (!(wr && rd))
    else $error("write and read together");
  a_select_first: assert property (s_src_wr |-> $past(sel_w) || $past(sel_w, 3))
    else $error("source written before global select");
  a_trim_follows: assert property (s_src_wr |=> wr && addr inside {8'h1B, 8'h1C})
    else $error("trim write missing");
  a_rmw_keeps: assert property (s_src_rd ##2 s_src_wr |-> (wdata & rdata) == rdata && (wdata | 16'h0006) == (rdata | 16'h0006))
    else $error("source bits changed");
  a_src_rd_bits: assert property (s_src_rd |=> rvalid && rdata[15:3] == 13'h0000)
    else $error("source upper bits set");
  a_imp_source: assert property (s_src_wr ##1 (wr && addr == 8'h1C) |-> $past(imp_bit))
    else $error("impedance source bit clear");
  a_cm_source: assert property (s_src_wr ##1 (wr && addr == 8'h1B) |-> $past(cm_bit))
    else $error("common-mode source bit clear");
endmodule : tob_props

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic i_start = 1'b0;
  logic i_common_mode = 1'b0;
  logic i_keep = 1'b0;
  logic [15:0] i_value = 16'h0000;
  logic o_done;
  logic o_busy;
  logic o_offset_from_serial;
  logic [4:0] sw;
  logic [3:0] imp1, imp2, pd;
  logic [4:0] cm1, cm2;
  int n_errors = 0;
  int n_compared = 0;
  tob_if bus();
  tob_if bus2();
  tob_host u_tob_host (.i_clock(i_clock), .i_resetn(i_resetn), .bus(bus.host), .i_start(i_start),
    .i_common_mode(i_common_mode), .i_keep(i_keep), .i_value(i_value), .o_busy(o_busy), .o_done(o_done));
  tob_device u_tob_device (.i_clock(i_clock), .i_resetn(i_resetn), .bus(bus.device), .i_fuse_impedance(4'h5),
    .i_fuse_common_mode(5'h0A), .o_impedance_trim(imp1), .o_common_mode_trim(cm1), .o_offset_from_serial(),
    .o_swing_standard(), .o_swing_data(), .o_swing_ready(), .o_swing_parity(), .o_swing_in_range(),
    .o_core_power_down());
  tob_device u_tob_device_2 (.i_clock(i_clock), .i_resetn(i_resetn), .bus(bus2.device), .i_fuse_impedance(4'h5),
    .i_fuse_common_mode(5'h0A), .o_impedance_trim(imp2), .o_common_mode_trim(cm2),
    .o_offset_from_serial(o_offset_from_serial), .o_swing_standard(sw[0]), .o_swing_data(sw[1]),
    .o_swing_ready(sw[2]), .o_swing_parity(sw[3]), .o_swing_in_range(sw[4]), .o_core_power_down(pd));
  tob_props u_tob_props (.i_clock(i_clock), .i_resetn(i_resetn), .wr(bus.wr), .rd(bus.rd), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid));
  initial
  begin
    forever #25 i_clock = ~i_clock;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr2(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clock);
    bus2.wr = 1'b1;
    bus2.addr = a;
    bus2.wdata = d;
    @(negedge i_clock);
    bus2.wr = 1'b0;
  endtask : wr2
  task rd2(input logic [7:0] a, input logic [15:0] e);
    @(negedge i_clock);
    bus2.rd = 1'b1;
    bus2.addr = a;
    @(negedge i_clock);
    bus2.rd = 1'b0;
    chk({15'h0000, bus2.rvalid}, 16'h0001);
    chk(bus2.rdata, e);
  endtask : rd2
  task run(input logic cm, input logic keep, input logic [15:0] v);
    int k;
    @(negedge i_clock);
    i_start = 1'b1;
    i_common_mode = cm;
    i_keep = keep;
    i_value = v;
    @(negedge i_clock);
    i_start = 1'b0;
    chk({15'h0000, o_busy}, 16'h0001);
    for (k = 0; k < 20 && o_done !== 1'b1; k++) @(negedge i_clock);
    chk({15'h0000, o_done}, 16'h0001);
    chk({15'h0000, o_busy}, 16'h0000);
  endtask : run
  task t_host;
    run(1'b0, 1'b0, 16'h000C);
    chk({12'h000, imp1}, 16'h000C);
    chk({11'h000, cm1}, 16'h000A);
    run(1'b1, 1'b1, 16'h0013);
    chk({11'h000, cm1}, 16'h0013);
    chk({12'h000, imp1}, 16'h000C);
    run(1'b1, 1'b0, 16'h0007);
    chk({11'h000, cm1}, 16'h0007);
    chk({12'h000, imp1}, 16'h0005);
  endtask : t_host
  task t_reset_values;
    rd2(8'h16, 16'h0000);
    rd2(8'h1B, 16'h0010);
    rd2(8'h1C, 16'h8000);
    rd2(8'h6A, 16'h0000);
    rd2(8'h6F, 16'h000A);
    rd2(8'h70, 16'h0005);
    rd2(8'h40, 16'h0000);
    chk({12'h000, imp2}, 16'h0005);
    chk({11'h000, cm2}, 16'h000A);
  endtask : t_reset_values
  task t_swing;
    chk({11'h000, sw}, 16'h0000);
    wr2(8'h6A, 16'h0001);
    chk({11'h000, sw}, 16'h001F);
    wr2(8'h6A, 16'h0000);
    chk({11'h000, sw}, 16'h0000);
  endtask : t_swing
  task t_source;
    wr2(8'h1B, 16'h0015);
    wr2(8'h1C, 16'h000B);
    rd2(8'h6F, 16'h000A);
    rd2(8'h70, 16'h0005);
    chk({15'h0000, o_offset_from_serial}, 16'h0000);
    wr2(8'h16, 16'hFFFF);
    rd2(8'h16, 16'h0007);
    chk({15'h0000, o_offset_from_serial}, 16'h0001);
    rd2(8'h6F, 16'h0015);
    rd2(8'h70, 16'h000B);
    chk({12'h000, imp2}, 16'h000B);
    chk({11'h000, cm2}, 16'h0015);
  endtask : t_source
  task t_power;
    wr2(8'h01, 16'h0000);
    wr2(8'h5C, 16'h0001);
    chk({12'h000, pd}, 16'h0001);
    wr2(8'h01, 16'h0003);
    wr2(8'h5C, 16'h0001);
    chk({12'h000, pd}, 16'h0009);
    rd2(8'h5C, 16'h0001);
    rd2(8'h01, 16'h0003);
    wr2(8'h01, 16'h0004);
    wr2(8'h5C, 16'h0000);
    chk({12'h000, pd}, 16'h0000);
    wr2(8'h5C, 16'h0001);
    chk({12'h000, pd}, 16'h000F);
  endtask : t_power
  task results;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    bus2.wr = 1'b0;
    bus2.rd = 1'b0;
    bus2.addr = 8'h00;
    bus2.wdata = 16'h0000;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    i_resetn = 1'b1;
    t_reset_values();
    t_swing();
    t_source();
    t_power();
    t_host();
    results();
  end
  initial
  begin
    #100000;
    n_errors++;
    results();
  end
endmodule : tb
